// ---- dv/ocs_osc_ctrl_asserts.sv ----
// Concurrent checks on the ports of the oscillator control block.
// Assumes one clock domain on clk with synchronous active-low rst_n.
`timescale 1ns/1ps
module ocs_osc_ctrl_asserts (
	// Clock and reset
	input wire logic              clk,
	input wire logic              rst_n,
	// Bus response
	input wire logic              hreadyout,
	input wire logic              hresp,
	// Fuse and requests
	input wire logic              trim_lock_fuse_bit,
	input wire logic [1:0]        rc_module_req,
	input wire logic              crystal_module_req,
	input wire ocs_pkg::ocs_src_t main_select,
	// Oscillator state
	input wire logic [1:0]        rc_run,
	input wire logic [1:0]        rc_gate_open,
	input wire logic              crystal_run,
	input wire logic              crystal_gate_open,
	input wire logic              crystal_pins_claimed,
	input wire logic              crystal_ext_clock,
	input wire logic [1:0]        crystal_startup_count,
	input wire logic [5:0]        fast_rc_fine_trim,
	input wire logic [3:0]        fast_rc_tempco_trim,
	input wire ocs_pkg::ocs_src_t main_source,
	input wire logic              main_switch_pending
);
	import ocs_pkg::*;

	// Single domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Bus answers at once and never errors, even on refused writes
	bus_okay_a: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	bus_ready_a: assert property ($past(rst_n) |-> hreadyout)
		else $error("bus stalled");
	// Slow RC delivers only when someone asks; two cycles of slack for the drop
	slow_gate_req_a: assert property (rc_gate_open[1] |-> rc_module_req[1]
		|| $past(rc_module_req[1]) || $past(rc_module_req[1], 2)
		|| main_select == OCS_SRC_SLOW || $past(main_source) == OCS_SRC_SLOW)
		else $error("slow gate open without request");
	// Four oscillator edges at least separate power-up from gate opening
	rc_gate_delay_a: assert property ($rose(rc_gate_open[1]) |-> $past(rc_run[1], 8))
		else $error("slow gate opened too soon");
	xtal_gate_req_a: assert property (crystal_gate_open |-> crystal_module_req
		|| $past(crystal_module_req) || $past(crystal_module_req, 2)
		|| main_select == OCS_SRC_XTAL || main_source == OCS_SRC_XTAL)
		else $error("crystal gate open without request");
	xtal_gate_run_a: assert property ($rose(crystal_gate_open) |->
		crystal_run && crystal_pins_claimed && $past(crystal_run, 4))
		else $error("crystal gate open while not running");
	// Type and count are frozen once the pins are claimed
	xtal_frozen_a: assert property ($past(crystal_pins_claimed) |->
		$stable(crystal_ext_clock) && $stable(crystal_startup_count))
		else $error("crystal type or count changed while enabled");
	trim_locked_a: assert property (trim_lock_fuse_bit && $past(rst_n) |->
		$stable(fast_rc_fine_trim) && $stable(fast_rc_tempco_trim))
		else $error("trim changed while locked");
	switch_flag_a: assert property (main_select != main_source
		&& $past(main_select != main_source) |-> main_switch_pending)
		else $error("switch flag low during a switch");
	switch_done_a: assert property ($fell(main_switch_pending) |-> main_source == main_select)
		else $error("switch flag fell before source changed");

	// Main scenarios reached
	cover property ($rose(main_switch_pending));
	cover property ($rose(crystal_gate_open));
	cover property ($rose(rc_gate_open[1]));
endmodule

bind ocs_osc_ctrl ocs_osc_ctrl_asserts ocs_osc_ctrl_asserts_inst (.clk, .rst_n, .hreadyout,
	.hresp, .trim_lock_fuse_bit, .rc_module_req, .crystal_module_req, .main_select, .rc_run,
	.rc_gate_open, .crystal_run, .crystal_gate_open, .crystal_pins_claimed, .crystal_ext_clock,
	.crystal_startup_count, .fast_rc_fine_trim, .fast_rc_tempco_trim, .main_source,
	.main_switch_pending);

// ---- dv/oscillator_control_status_tb.sv ----
// Self-checking bench for the oscillator control block over AHB-Lite.
// Assumes the constants header and package are compiled alongside the design.
`timescale 1ns/1ps
`include "ocs_consts.svh"
module oscillator_control_status_tb;
	import ocs_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [1:0] htrans = 2'h0, rreq = 2'h0;
	logic xreq = 1'b0, fsel = 1'b1, flock = 1'b0, ext_st = 1'b0;
	logic [5:0] ft16 = 6'h11, ft20 = 6'h2A;
	logic [3:0] ftc = 4'h9;
	logic [2:0] oc = 3'h0;
	ocs_src_t msel = OCS_SRC_FAST;
	wire hreadyout, hresp, crystal_run, crystal_gate_open, crystal_pins_claimed;
	wire crystal_ext_clock, main_switch_pending;
	wire [31:0] hrdata;
	wire [1:0] rc_run, rc_gate_open, xcsut;
	wire [5:0] ftrim;
	wire [3:0] ftco;
	ocs_src_t main_source;
	int fails = 0, cmp_count = 0, n;
	int su[4] = '{1024, 8, 12, 16};

	// Short warm-up counts keep the run brief
	ocs_osc_ctrl #(.XT_SU_16K(17'h00008), .XT_SU_32K(17'h0000C), .XT_SU_64K(17'h00010),
		.RC_ANA_SU(17'h00004)) ocs_osc_ctrl_inst (.clk, .rst_n, .ce(1'b1), .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .frequency_select_fuse(fsel), .trim_lock_fuse_bit(flock),
		.fuse_fine_trim_16m(ft16), .fuse_fine_trim_20m(ft20), .fuse_tempco_trim(ftc),
		.fast_rc_oscillator(oc[1]), .slow_rc_oscillator(oc[2]), .crystal_oscillator(oc[1]),
		.rc_module_req(rreq), .crystal_module_req(xreq), .main_select(msel),
		.ext_clk_stable(ext_st), .rc_run, .rc_gate_open, .crystal_run, .crystal_gate_open,
		.crystal_pins_claimed, .crystal_ext_clock, .crystal_startup_count(xcsut),
		.fast_rc_fine_trim(ftrim), .fast_rc_tempco_trim(ftco), .main_source,
		.main_switch_pending);

	// Clock and oscillator stand-ins; each level lasts two clk cycles or more
	always #12.5 clk = ~clk;
	always @(posedge clk) oc <= oc + 3'h1;

	// Single word transfer; the master waits on ready in both phases
	task automatic xfer(input logic [7:0] i, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		hsel <= 1'b1;
		haddr <= {22'h0, i, 2'b00};
		htrans <= 2'h2;
		hwrite <= w;
		// Only the watchdog ends a stalled wait
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata[7:0];
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] q;
		xfer(i, 1'b1, d, q);
	endtask
	// Key write directly followed by the guarded write
	task automatic pwr(input logic [7:0] i, input logic [7:0] d);
		wr(`OCS_IDX_KEY, `OCS_KEY_VALUE);
		wr(i, d);
	endtask
	task automatic rc(input logic [7:0] i, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] q;
		xfer(i, 1'b0, 8'h00, q);
		chk({24'h0, q & m}, {24'h0, e});
	endtask
	task automatic wxg(input int lim);
		n = 0;
		while (crystal_gate_open !== 1'b1 && n < lim) begin @(posedge clk); n++; end
	endtask
	task automatic rst;
		rst_n <= 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Hang guard, well beyond the longest crystal warm-up
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		close_out();
	end

	// Test sequence
	initial begin
		rst();
		rc(`OCS_IDX_FAST_CTRL, 8'hFF, 8'h00);
		rc(`OCS_IDX_SLOW_CTRL, 8'hFF, 8'h00);
		rc(`OCS_IDX_XTAL_CTRL, 8'hFF, 8'h00);
		rc(`OCS_IDX_FAST_TRIM, 8'hFF, 8'h2A);
		rc(`OCS_IDX_FAST_TCO, 8'hFF, 8'h09);
		rc(8'h05, 8'hFF, 8'h00);
		$display("test 1 done");
		wr(`OCS_IDX_SLOW_CTRL, 8'h02);
		rc(`OCS_IDX_SLOW_CTRL, 8'hFF, 8'h00);
		chk(hresp, 1'b0);
		pwr(`OCS_IDX_SLOW_CTRL, 8'hFF);
		rc(`OCS_IDX_SLOW_CTRL, 8'hFF, 8'h02);
		repeat (100) @(posedge clk);
		chk(rc_run[1], 1'b1);
		chk(rc_gate_open[1], 1'b0);
		chk(rc_gate_open[0], 1'b1);
		rc(`OCS_IDX_STATUS, 8'h20, 8'h00);
		rreq <= 2'b10;
		repeat (20) @(posedge clk);
		chk(rc_gate_open[1], 1'b0);
		repeat (30) @(posedge clk);
		chk(rc_gate_open[1], 1'b1);
		rc(`OCS_IDX_STATUS, 8'h20, 8'h20);
		rreq <= 2'b00;
		repeat (3) @(posedge clk);
		chk(rc_gate_open[1], 1'b0);
		wr(`OCS_IDX_KEY, `OCS_KEY_VALUE);
		repeat (6) @(posedge clk);
		wr(`OCS_IDX_SLOW_CTRL, 8'h00);
		rc(`OCS_IDX_SLOW_CTRL, 8'hFF, 8'h02);
		$display("test 2 done");
		pwr(`OCS_IDX_FAST_TRIM, 8'h15);
		rc(`OCS_IDX_FAST_TRIM, 8'hFF, 8'h15);
		pwr(`OCS_IDX_FAST_TCO, 8'h83);
		rc(`OCS_IDX_FAST_TCO, 8'hFF, 8'h03);
		fsel <= 1'b0;
		flock <= 1'b1;
		ft20 <= 6'h05;
		ftc <= 4'h6;
		rst();
		rc(`OCS_IDX_FAST_TRIM, 8'hFF, 8'h11);
		rc(`OCS_IDX_FAST_TCO, 8'hFF, 8'h86);
		pwr(`OCS_IDX_FAST_TRIM, 8'h3F);
		pwr(`OCS_IDX_FAST_TCO, 8'h01);
		rc(`OCS_IDX_FAST_TRIM, 8'hFF, 8'h11);
		rc(`OCS_IDX_FAST_TCO, 8'hFF, 8'h86);
		chk(ftrim, 6'h11);
		chk(ftco, 4'h6);
		$display("test 3 done");
		for (int c = 0; c < 4; c++) begin
			pwr(`OCS_IDX_XTAL_CTRL, {2'b00, c[1:0], 4'b0001});
			pwr(`OCS_IDX_XTAL_CTRL, 8'h05);
			rc(`OCS_IDX_XTAL_CTRL, 8'hFF, {2'b00, c[1:0], 4'b0001});
			chk(crystal_run, 1'b0);
			chk(crystal_pins_claimed, 1'b1);
			chk(xcsut, c[1:0]);
			xreq <= 1'b1;
			wxg(6000);
			chk(n >= su[c] * 4 && n <= su[c] * 4 + 32, 1'b1);
			xreq <= 1'b0;
			pwr(`OCS_IDX_XTAL_CTRL, 8'h00);
			repeat (4) @(posedge clk);
			rc(`OCS_IDX_STATUS, 8'h40, 8'h00);
		end
		pwr(`OCS_IDX_XTAL_CTRL, 8'h35);
		// The write lands at the edge that ends the data phase
		@(posedge clk);
		chk(crystal_ext_clock, 1'b1);
		xreq <= 1'b1;
		wxg(200);
		chk(n <= 24, 1'b1);
		xreq <= 1'b0;
		pwr(`OCS_IDX_XTAL_CTRL, 8'h00);
		repeat (4) @(posedge clk);
		pwr(`OCS_IDX_XTAL_CTRL, 8'h13);
		repeat (100) @(posedge clk);
		chk(crystal_run, 1'b1);
		rc(`OCS_IDX_STATUS, 8'h40, 8'h00);
		chk(crystal_gate_open, 1'b0);
		xreq <= 1'b1;
		wxg(100);
		chk(n <= 20, 1'b1);
		xreq <= 1'b0;
		repeat (3) @(posedge clk);
		chk(crystal_gate_open, 1'b0);
		wr(`OCS_IDX_XTAL_CTRL, 8'h00);
		rc(`OCS_IDX_XTAL_CTRL, 8'hFF, 8'h13);
		$display("test 4 done");
		msel <= OCS_SRC_SLOW;
		repeat (3) @(posedge clk);
		chk(main_switch_pending, 1'b1);
		rc(`OCS_IDX_STATUS, 8'h01, 8'h01);
		n = 0;
		while (main_source !== OCS_SRC_SLOW && n < 500) begin @(posedge clk); n++; end
		chk(main_source, OCS_SRC_SLOW);
		repeat (2) @(posedge clk);
		rc(`OCS_IDX_STATUS, 8'h21, 8'h20);
		chk(rc_gate_open[0], 1'b0);
		// A stable external clock takes over at once
		ext_st <= 1'b1;
		msel <= OCS_SRC_EXT;
		repeat (3) @(posedge clk);
		chk(main_source, OCS_SRC_EXT);
		chk(main_switch_pending, 1'b0);
		chk(rc_gate_open[1], 1'b0);
		rc(`OCS_IDX_STATUS, 8'hA1, 8'h80);
		$display("test 5 done");
		close_out();
	end
endmodule

// ---- pkg/ocs_consts.svh ----
// Offsets, field positions, reset values and counts of the oscillator control block.
// Assumes a 32-bit AHB-Lite bus with one 8-bit register in each aligned word.
`ifndef OCS_CONSTS_SVH
`define OCS_CONSTS_SVH

// Register indexes; byte address is four times the index
`define OCS_IDX_STATUS    8'h03
`define OCS_IDX_FAST_CTRL 8'h10
`define OCS_IDX_FAST_TRIM 8'h11
`define OCS_IDX_FAST_TCO  8'h12
`define OCS_IDX_SLOW_CTRL 8'h18
`define OCS_IDX_XTAL_CTRL 8'h1C
`define OCS_IDX_KEY       8'h20

// Change-protection key and window length in bus cycles
`define OCS_KEY_VALUE     8'hA5
`define OCS_KEY_WINDOW    3'h4

// Field positions
`define OCS_BIT_EN        0
`define OCS_BIT_RSB       1
`define OCS_BIT_SEL       2
`define OCS_BIT_CRYSTAL_STARTUP_COUNT_LO   4
`define OCS_BIT_CRYSTAL_STARTUP_COUNT_HI   5
`define OCS_BIT_LOCK      7
`define OCS_BIT_FAST_ST   4
`define OCS_BIT_SLOW_ST   5
`define OCS_BIT_XTAL_ST   6
`define OCS_BIT_EXT_ST    7
`define OCS_BIT_PENDING   0

// Reset values
`define OCS_RST_CTRL      8'h00

// Oscillator cycle counts
`define OCS_GATE_CYC      17'h00004
`define OCS_XT_GATE_CYC   17'h00002
`define OCS_XT_SU_1K      17'h00400
`define OCS_XT_SU_16K     17'h04000
`define OCS_XT_SU_32K     17'h08000
`define OCS_XT_SU_64K     17'h10000
`define OCS_RC_ANALOG_SU  17'h00040

`endif

// ---- pkg/ocs_pkg.sv ----
// Types shared by the oscillator control block.
// Assumes the constants header is included alongside.
package ocs_pkg;

	// Main clock sources
	typedef enum logic [1:0] {
		OCS_SRC_FAST = 2'b00,
		OCS_SRC_SLOW = 2'b01,
		OCS_SRC_XTAL = 2'b10,
		OCS_SRC_EXT  = 2'b11
	} ocs_src_t;

	// Crystal sequencer states
	typedef enum logic [1:0] {
		OCS_XT_IDLE  = 2'b00,
		OCS_XT_WARM  = 2'b01,
		OCS_XT_READY = 2'b10,
		OCS_XT_ON    = 2'b11
	} ocs_xt_st_t;

endpackage

// ---- rtl/ocs_osc_ctrl.sv ----
// Oscillator control and status: RC oscillator forcing and gating, fast RC trim with
// fuse lock, crystal sequencer, main clock switch flag, AHB-Lite register slave.
// Assumes oscillator clocks arrive as raw pin levels, fuses are stable during reset,
// and request inputs come from logic on clk.
`timescale 1ns/1ps
`include "ocs_consts.svh"

// Functional notes
// - RC stable flag only while requested
// - Switch flag high until new source stable
// - RC run-in-standby forces oscillator running
// - No RC clock out without request
// - Gate opens after 4 cycles, skip analog
// - Fine trim field bits 5:0
// - Tempco trim field bits 3:0
// - Lock flag blocks both trim registers
// - Lock flag loaded from fuse at reset
// - Type and count frozen while enabled/stable
// - Count field picks 1k/16k/32k/64k cycles
// - External clock skips crystal start-up
// - Type bit: crystal or external clock
// - Crystal run-in-standby keeps it running
// - Crystal output only while requested
// - Forced crystal delivers in 2-3 cycles
// - Crystal standby bit is write protected
// - Key then protected write within window
// - Unkeyed write accepted, contents unchanged
// - Enable claims pins, freezes type/count
module ocs_osc_ctrl #(
	parameter logic [16:0] XT_SU_16K = `OCS_XT_SU_16K,
	parameter logic [16:0] XT_SU_32K = `OCS_XT_SU_32K,
	parameter logic [16:0] XT_SU_64K = `OCS_XT_SU_64K,
	parameter logic [16:0] RC_ANA_SU = `OCS_RC_ANALOG_SU
) (
	// Clock, reset, enable
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// Fuses
	input  wire logic              frequency_select_fuse,
	input  wire logic              trim_lock_fuse_bit,
	input  wire logic [5:0]        fuse_fine_trim_16m,
	input  wire logic [5:0]        fuse_fine_trim_20m,
	input  wire logic [3:0]        fuse_tempco_trim,
	// Oscillator clocks from the pads or analog cells
	input  wire logic              fast_rc_oscillator,
	input  wire logic              slow_rc_oscillator,
	input  wire logic              crystal_oscillator,
	// Clock requests and main clock selection
	input  wire logic [1:0]        rc_module_req,
	input  wire logic              crystal_module_req,
	input  wire ocs_pkg::ocs_src_t main_select,
	input  wire logic              ext_clk_stable,
	// Oscillator controls and status
	output logic [1:0]             rc_run,
	output logic [1:0]             rc_gate_open,
	output logic                   crystal_run,
	output logic                   crystal_gate_open,
	output logic                   crystal_pins_claimed,
	output logic                   crystal_ext_clock,
	output logic [1:0]             crystal_startup_count,
	output logic [5:0]             fast_rc_fine_trim,
	output logic [3:0]             fast_rc_tempco_trim,
	output ocs_pkg::ocs_src_t      main_source,
	output logic                   main_switch_pending
);
	import ocs_pkg::*;

	// Bus state
	logic        hreadyout_ff;
	logic [31:0] hrdata_ff;
	logic        dph_wr_ff;
	logic [7:0]  dph_idx_ff;
	logic [2:0]  key_win_ff;
	// Control registers
	logic [1:0]  rc_rsb_ff;
	logic [5:0]  fine_ff;
	logic [3:0]  tco_ff;
	logic        lock_ff;
	logic        xt_en_ff;
	logic        xt_rsb_ff;
	logic        xt_sel_ff;
	logic [1:0]  xt_crystal_startup_count_ff;
	// Oscillator state
	logic [2:0]  osc_s1_ff;
	logic [2:0]  osc_s2_ff;
	logic [2:0]  osc_s3_ff;
	logic [1:0]  rc_run_ff;
	logic [1:0]  rc_stable_ff;
	ocs_xt_st_t  xt_st_ff;
	ocs_xt_st_t  nxt_xt_st;
	logic [16:0] xt_cnt_ff;
	logic [16:0] nxt_xt_cnt;
	logic        xt_run_ff;
	logic        xt_gate_ff;
	ocs_src_t    cur_src_ff;
	logic        pending_ff;

	// Address phase and data phase decode
	wire       addr_ok   = hsel & htrans[1] & hready;
	wire [7:0] a_idx     = haddr[9:2];
	wire       wr_now    = dph_wr_ff;
	wire [7:0] wbyte     = hwdata[7:0];
	wire       key_write = wr_now & (dph_idx_ff == `OCS_IDX_KEY) & (wbyte == `OCS_KEY_VALUE);
	wire       unlocked  = (key_win_ff != 3'h0);
	wire       prot_wr   = wr_now & unlocked & (dph_idx_ff != `OCS_IDX_KEY);
	wire       wr_fctl   = prot_wr & (dph_idx_ff == `OCS_IDX_FAST_CTRL);
	wire       wr_trim   = prot_wr & (dph_idx_ff == `OCS_IDX_FAST_TRIM) & ~lock_ff;
	wire       wr_tco    = prot_wr & (dph_idx_ff == `OCS_IDX_FAST_TCO) & ~lock_ff;
	wire       wr_sctl   = prot_wr & (dph_idx_ff == `OCS_IDX_SLOW_CTRL);
	wire       wr_xctl   = prot_wr & (dph_idx_ff == `OCS_IDX_XTAL_CTRL);
	// Type and count may change only with the crystal off and not stable
	wire       xt_cfg_ok = ~xt_en_ff & (xt_st_ff != OCS_XT_ON);

	// Requests per source: modules, the current main source, and a pending target
	wire [3:0] src_req;
	wire [3:0] src_stable;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_req
			wire is_src = (cur_src_ff == ocs_src_t'(gi)) | (main_select == ocs_src_t'(gi));
			if (gi < 2) begin : g_rc
				assign src_req[gi] = rc_module_req[gi] | is_src;
			end else if (gi == 2) begin : g_xt
				assign src_req[gi] = crystal_module_req | is_src;
			end else begin : g_ext
				assign src_req[gi] = is_src;
			end
		end
	endgenerate
	assign src_stable = {ext_clk_stable, xt_st_ff == OCS_XT_ON, rc_stable_ff};

	// Oscillator edge detection after a two-flop synchroniser
	wire [2:0] osc_tick = osc_s2_ff & ~osc_s3_ff;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			osc_s1_ff <= 3'h0;
			osc_s2_ff <= 3'h0;
			osc_s3_ff <= 3'h0;
		end else if (ce) begin
			osc_s1_ff <= {crystal_oscillator, slow_rc_oscillator, fast_rc_oscillator};
			osc_s2_ff <= osc_s1_ff;
			osc_s3_ff <= osc_s2_ff;
		end
	end

	// RC oscillators: analog start-up, then a four-cycle gate delay per request
	generate
		for (gi = 0; gi < 2; gi++) begin : g_rc_osc
			logic [16:0] asu_ff;
			logic [16:0] gcnt_ff;
			// Forced running also skips the analog warm-up
			wire rc_on   = src_req[gi] | rc_rsb_ff[gi];
			wire warm    = rc_rsb_ff[gi] | (asu_ff >= RC_ANA_SU);
			wire gate_up = (gcnt_ff + 17'h1 >= `OCS_GATE_CYC);
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					asu_ff          <= 17'h0;
					gcnt_ff         <= 17'h0;
					rc_run_ff[gi]   <= 1'b0;
					rc_stable_ff[gi] <= 1'b0;
				end else if (ce) begin
					rc_run_ff[gi] <= rc_on;
					if (!rc_on) begin
						asu_ff <= 17'h0;
					end else if (osc_tick[gi] && !warm) begin
						asu_ff <= asu_ff + 17'h1;
					end
					// Withdrawn request closes the gate and drops the flag
					if (!src_req[gi]) begin
						gcnt_ff          <= 17'h0;
						rc_stable_ff[gi] <= 1'b0;
					end else if (warm && osc_tick[gi] && !rc_stable_ff[gi]) begin
						gcnt_ff <= gcnt_ff + 17'h1;
						if (gate_up) begin
							rc_stable_ff[gi] <= 1'b1;
						end
					end
				end
			end
		end
	endgenerate

	// Crystal start-up length; an external clock needs only the two-cycle gate count
	wire [16:0] xt_su_len = xt_sel_ff ? `OCS_XT_GATE_CYC :
		(xt_crystal_startup_count_ff == 2'h0) ? `OCS_XT_SU_1K :
		(xt_crystal_startup_count_ff == 2'h1) ? XT_SU_16K :
		(xt_crystal_startup_count_ff == 2'h2) ? XT_SU_32K : XT_SU_64K;
	wire xt_on_req = xt_en_ff & (xt_rsb_ff | src_req[2]);
	wire [16:0] xt_cnt_inc = xt_cnt_ff + 17'h1;

	// Crystal sequencer: warm up once per start, then gate per request
	always_comb begin
		nxt_xt_st  = xt_st_ff;
		nxt_xt_cnt = xt_cnt_ff;
		case (xt_st_ff)
			OCS_XT_IDLE: begin
				nxt_xt_cnt = 17'h0;
				if (xt_on_req) begin
					nxt_xt_st = OCS_XT_WARM;
				end
			end
			OCS_XT_WARM: begin
				if (osc_tick[2]) begin
					nxt_xt_cnt = xt_cnt_inc;
					if (xt_cnt_inc >= xt_su_len) begin
						nxt_xt_st  = OCS_XT_READY;
						nxt_xt_cnt = 17'h0;
					end
				end
			end
			OCS_XT_READY: begin
				if (!src_req[2]) begin
					nxt_xt_cnt = 17'h0;
				end else if (osc_tick[2]) begin
					nxt_xt_cnt = xt_cnt_inc;
					if (xt_cnt_inc >= `OCS_XT_GATE_CYC) begin
						nxt_xt_st = OCS_XT_ON;
					end
				end
			end
			OCS_XT_ON: begin
				nxt_xt_cnt = 17'h0;
				if (!src_req[2]) begin
					nxt_xt_st = OCS_XT_READY;
				end
			end
			default: begin
				nxt_xt_st  = OCS_XT_IDLE;
				nxt_xt_cnt = 17'h0;
			end
		endcase
		// Stopping the crystal loses its warm-up
		if (!xt_on_req) begin
			nxt_xt_st  = OCS_XT_IDLE;
			nxt_xt_cnt = 17'h0;
		end
	end

	// Crystal state registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			xt_st_ff  <= OCS_XT_IDLE;
			xt_cnt_ff <= 17'h0;
			xt_run_ff <= 1'b0;
			xt_gate_ff <= 1'b0;
		end else if (ce) begin
			xt_st_ff  <= nxt_xt_st;
			xt_cnt_ff <= nxt_xt_cnt;
			xt_run_ff <= xt_on_req;
			xt_gate_ff <= (nxt_xt_st == OCS_XT_ON);
		end
	end

	// Main clock switch: hold the old source until the new one is stable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cur_src_ff <= OCS_SRC_FAST;
			pending_ff <= 1'b0;
		end else if (ce) begin
			if (main_select != cur_src_ff && src_stable[main_select]) begin
				cur_src_ff <= main_select;
				pending_ff <= 1'b0;
			end else begin
				pending_ff <= (main_select != cur_src_ff);
			end
		end
	end

	// Protection window: opened by the key, closed by use or timeout
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			key_win_ff <= 3'h0;
		end else if (ce) begin
			if (key_write) begin
				key_win_ff <= `OCS_KEY_WINDOW;
			end else if (prot_wr) begin
				key_win_ff <= 3'h0;
			end else if (unlocked) begin
				key_win_ff <= key_win_ff - 3'h1;
			end
		end
	end

	// Control and trim registers; trims and lock load from fuses at reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rc_rsb_ff  <= 2'h0;
			fine_ff    <= frequency_select_fuse ? fuse_fine_trim_20m
			                                   : fuse_fine_trim_16m;
			tco_ff     <= fuse_tempco_trim;
			lock_ff    <= trim_lock_fuse_bit;
			xt_en_ff   <= 1'b0;
			xt_rsb_ff  <= 1'b0;
			xt_sel_ff  <= 1'b0;
			xt_crystal_startup_count_ff <= 2'h0;
		end else if (ce) begin
			if (wr_fctl) begin
				rc_rsb_ff[0] <= wbyte[`OCS_BIT_RSB];
			end
			if (wr_sctl) begin
				rc_rsb_ff[1] <= wbyte[`OCS_BIT_RSB];
			end
			if (wr_trim) begin
				fine_ff <= wbyte[5:0];
			end
			if (wr_tco) begin
				tco_ff <= wbyte[3:0];
			end
			if (wr_xctl) begin
				xt_en_ff  <= wbyte[`OCS_BIT_EN];
				xt_rsb_ff <= wbyte[`OCS_BIT_RSB];
				if (xt_cfg_ok) begin
					xt_sel_ff  <= wbyte[`OCS_BIT_SEL];
					xt_crystal_startup_count_ff <= wbyte[`OCS_BIT_CRYSTAL_STARTUP_COUNT_HI:`OCS_BIT_CRYSTAL_STARTUP_COUNT_LO];
				end
			end
		end
	end

	// Read mux; unused bits and unmapped words read zero
	wire [7:0] rd_status = {ext_clk_stable, xt_st_ff == OCS_XT_ON, rc_stable_ff[1],
		rc_stable_ff[0], 3'h0, pending_ff};
	wire [7:0] rd_byte =
		(a_idx == `OCS_IDX_STATUS)    ? rd_status :
		(a_idx == `OCS_IDX_FAST_CTRL) ? {6'h00, rc_rsb_ff[0], 1'b0} :
		(a_idx == `OCS_IDX_FAST_TRIM) ? {2'h0, fine_ff} :
		(a_idx == `OCS_IDX_FAST_TCO)  ? {lock_ff, 3'h0, tco_ff} :
		(a_idx == `OCS_IDX_SLOW_CTRL) ? {6'h00, rc_rsb_ff[1], 1'b0} :
		(a_idx == `OCS_IDX_XTAL_CTRL) ? {2'h0, xt_crystal_startup_count_ff, 1'b0, xt_sel_ff, xt_rsb_ff,
		                                 xt_en_ff} : 8'h00;

	// Bus phases: zero wait states, read data registered in the address phase
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hreadyout_ff <= 1'b0;
			hrdata_ff    <= 32'h0;
			dph_wr_ff    <= 1'b0;
			dph_idx_ff   <= 8'h00;
		end else if (ce) begin
			hreadyout_ff <= 1'b1;
			if (hready) begin
				dph_wr_ff  <= addr_ok & hwrite;
				dph_idx_ff <= a_idx;
				hrdata_ff  <= (addr_ok && !hwrite) ? {24'h0, rd_byte} : 32'h0;
			end
		end
	end

	// Outputs straight from flip-flops
	assign hreadyout             = hreadyout_ff;
	assign hresp                 = 1'b0 & hreadyout_ff;
	assign hrdata                = hrdata_ff;
	assign rc_run                = rc_run_ff;
	assign rc_gate_open          = rc_stable_ff;
	assign crystal_run           = xt_run_ff;
	assign crystal_gate_open     = xt_gate_ff;
	assign crystal_pins_claimed  = xt_en_ff;
	assign crystal_ext_clock     = xt_sel_ff;
	assign crystal_startup_count = xt_crystal_startup_count_ff;
	assign fast_rc_fine_trim     = fine_ff;
	assign fast_rc_tempco_trim   = tco_ff;
	assign main_source           = cur_src_ff;
	assign main_switch_pending   = pending_ff;

endmodule
